// File: design/rlef_pkg.sv
// Constants and types for the rail enable and suspend flag register bank
// Functional notes
// - After wake from suspend, a flag reads 1 if its rail stayed enabled.
// - Flags read 0 after power-up from off or for disabled rails; reset 0.
// - Unlock key register: eight bits, write-only (reads 0), reset zero.
// - Converter enable register at 0x11, reset 0x00, needs unlock.
// - Bits 0-5 enable bucks 1-4 and backups 5, 6; bits 7-6 read 0.
// - Backup 6 enable may clear only while the seal state is 0.
// - Backup 5 enable may clear only while the seal state is 0 or on a sequencer update.
// - Sequencer updates backup5, bucks, load switch 1 and linear regulator bits.
// - Switch enable register at 0x12, reset 0x00, needs unlock; bit 7 reads 0.
// - Bit 0 enables linear regulator, bits 1-3 enable load switches 1-3.
// - Bit 6 drives pin 3 low or HiZ; ignored when warm-reset select is 1.
// - Bit 5 drives output 2 low or HiZ; ignored when input select is 1.
// - Bit 4 drives output 1 low or HiZ; ignored when input select is 1.
// - With warm-reset select set, pin 3 is a warm-reset input to bucks 1, 2.
// - With input select set, pin 1 is an input controlling output 2.
// - Suspend flag register at 0x07, reset 0x00.
package rlef_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FLAG = 6'h07;
   localparam logic [5:0] IDX_KEY = 6'h10;
   localparam logic [5:0] IDX_CONV = 6'h11;
   localparam logic [5:0] IDX_SW = 6'h12;
   localparam logic [7:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
   localparam logic [7:0] ADDR_KEY = {IDX_KEY, 2'b00};
   localparam logic [7:0] ADDR_CONV = {IDX_CONV, 2'b00};
   localparam logic [7:0] ADDR_SW = {IDX_SW, 2'b00};

   // Reset values
   localparam logic [7:0] RST_FLAG = 8'h00;
   localparam logic [7:0] RST_KEY = 8'h00;
   localparam logic [5:0] RST_CONV = 6'h00;
   localparam logic [6:0] RST_SW = 7'h00;

   // Converter enable fields
   localparam int CONV_BUCK1 = 0;
   localparam int CONV_BUCK2 = 1;
   localparam int CONV_BUCK3 = 2;
   localparam int CONV_BUCK4 = 3;
   localparam int CONV_BACKUP5 = 4;
   localparam int CONV_BACKUP6 = 5;

   // Switch enable fields
   localparam int SW_LINREG = 0;
   localparam int SW_LOADSW1 = 1;
   localparam int SW_LOADSW2 = 2;
   localparam int SW_LOADSW3 = 3;
   localparam int SW_OUT1 = 4;
   localparam int SW_OUT2 = 5;
   localparam int SW_PIN3 = 6;

   // Arbitrary unlock key value
   localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5A;

   typedef enum {
      RLEF_SEL_NONE,
      RLEF_SEL_FLAG,
      RLEF_SEL_KEY,
      RLEF_SEL_CONV,
      RLEF_SEL_SW
   } rlef_sel_t;

   // Sequencer update of the enable bits it owns
   typedef struct packed {
      logic backup5;
      logic buck4;
      logic buck3;
      logic buck2;
      logic buck1;
      logic loadsw1;
      logic linreg;
   } rlef_seq_t;

   function automatic rlef_sel_t rlef_decode(input logic [7:0] addr);
      rlef_sel_t sel;
      sel = RLEF_SEL_NONE;
      if (addr == ADDR_FLAG) begin
         sel = RLEF_SEL_FLAG;
      end else if (addr == ADDR_KEY) begin
         sel = RLEF_SEL_KEY;
      end else if (addr == ADDR_CONV) begin
         sel = RLEF_SEL_CONV;
      end else if (addr == ADDR_SW) begin
         sel = RLEF_SEL_SW;
      end
      return sel;
   endfunction

endpackage

// File: design/rlef_unlock.sv
// Unlock sequence tracker for protected register writes
`timescale 1ns/1ps
module rlef_unlock
   import rlef_pkg::*;
#(
   parameter logic [7:0] KEY = UNLOCK_KEY_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Completed bus writes
   input wire logic wr_done,
   input wire logic wr_to_key,
   input wire logic [7:0] wr_data,
   // Permission for the current write
   output logic unlocked
);

   logic armed_q;

   // Only the write right after a correct key write is granted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (wr_done) begin
         armed_q <= wr_to_key && (wr_data == KEY);
      end
   end

   assign unlocked = armed_q;

endmodule

// File: design/rlef_top.sv
// Rail enable, unlock key and suspend flag register bank with APB slave
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module rlef_top
   import rlef_pkg::*;
#(
   parameter logic [7:0] KEY = UNLOCK_KEY_DEFAULT
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Power sequencer and state
   input wire logic SEQ_UPDATE,
   input wire rlef_seq_t SEQ_STATE,
   input wire logic SUSPEND_ENTRY,
   input wire logic POWERUP_DONE,
   input wire logic POWERUP_FROM_SUSPEND,
   input wire logic FRESH_SEAL_STATE,
   // Pin mode selectors
   input wire logic WARM_RESET_PIN_SELECT,
   input wire logic INPUT_SELECT,
   // Rail enables
   output logic [5:0] CONVERTER_ENABLES,
   output logic [3:0] SWITCH_ENABLES,
   // Pin 1, open drain or input
   input wire logic PIN1_IN,
   output logic PIN1_OUT,
   output logic PIN1_OE,
   // Output 2, open drain
   output logic OUT2_OUT,
   output logic OUT2_OE,
   // Pin 3, open drain or warm-reset input
   input wire logic PIN3_IN,
   output logic PIN3_OUT,
   output logic PIN3_OE,
   output logic BUCK12_WARM_RESET
);

   rlef_sel_t sel;
   logic access;
   logic wr_done;
   logic rd_done;
   logic unlocked;
   logic prot_wr_ok;
   logic [5:0] conv_q;
   logic [5:0] conv_d;
   logic [6:0] sw_q;
   logic [6:0] sw_d;
   logic [7:0] flag_q;
   logic [7:0] snap_q;
   logic [7:0] snap_d;
   logic [7:0] key_q;
   logic [31:0] rdata_d;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   assign sel = rlef_decode(PADDR);
   // One wait state keeps PREADY a flop without a combinational path
   assign access = PSEL && PENABLE;
   assign wr_done = access && pready_q && PWRITE;
   assign rd_done = access && pready_q && !PWRITE;
   assign prot_wr_ok = wr_done && unlocked;

   rlef_unlock #(
      .KEY(KEY)
   ) u_unlock (
      .clk(MCLK),
      .rst_n(NRST),
      .wr_done(wr_done),
      .wr_to_key(sel == RLEF_SEL_KEY),
      .wr_data(PWDATA[7:0]),
      .unlocked(unlocked)
   );

   // APB handshake
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= access && !pready_q;
      end
   end

   // Read data mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sel == RLEF_SEL_FLAG) begin
         rdata_d[7:0] = flag_q;
      end else if (sel == RLEF_SEL_KEY) begin
         rdata_d = 32'h0000_0000;
      end else if (sel == RLEF_SEL_CONV) begin
         rdata_d[5:0] = conv_q;
      end else if (sel == RLEF_SEL_SW) begin
         rdata_d[6:0] = sw_q;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (access && !pready_q) begin
         prdata_q <= PWRITE ? 32'h0000_0000 : rdata_d;
         pslverr_q <= (sel == RLEF_SEL_NONE);
      end else begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   // Key register stores but never reads back
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         key_q <= RST_KEY;
      end else if (wr_done && sel == RLEF_SEL_KEY) begin
         key_q <= PWDATA[7:0];
      end
   end

   // Converter enables: bus write, seal guard, then sequencer
   always_comb begin
      conv_d = conv_q;
      if (prot_wr_ok && sel == RLEF_SEL_CONV) begin
         conv_d = PWDATA[5:0];
         if (FRESH_SEAL_STATE) begin
            conv_d[CONV_BACKUP6] = PWDATA[CONV_BACKUP6] | conv_q[CONV_BACKUP6];
            conv_d[CONV_BACKUP5] = PWDATA[CONV_BACKUP5] | conv_q[CONV_BACKUP5];
         end
      end
      // Sequencer wins over a same-cycle bus write
      if (SEQ_UPDATE) begin
         conv_d[CONV_BUCK1] = SEQ_STATE.buck1;
         conv_d[CONV_BUCK2] = SEQ_STATE.buck2;
         conv_d[CONV_BUCK3] = SEQ_STATE.buck3;
         conv_d[CONV_BUCK4] = SEQ_STATE.buck4;
         conv_d[CONV_BACKUP5] = SEQ_STATE.backup5;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         conv_q <= RST_CONV;
      end else begin
         conv_q <= conv_d;
      end
   end

   // Switch and output enables
   always_comb begin
      sw_d = sw_q;
      if (prot_wr_ok && sel == RLEF_SEL_SW) begin
         sw_d = PWDATA[6:0];
      end
      if (SEQ_UPDATE) begin
         sw_d[SW_LINREG] = SEQ_STATE.linreg;
         sw_d[SW_LOADSW1] = SEQ_STATE.loadsw1;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sw_q <= RST_SW;
      end else begin
         sw_q <= sw_d;
      end
   end

   // Enable state held through suspend, 1 meaning enabled
   always_comb begin
      snap_d = {sw_q[SW_PIN3], sw_q[SW_OUT2], sw_q[SW_OUT1], sw_q[SW_LINREG], conv_q[3:0]};
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         snap_q <= RST_FLAG;
      end else if (SUSPEND_ENTRY) begin
         snap_q <= snap_d;
      end
   end

   // Flags change only when a power-up completes
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         flag_q <= RST_FLAG;
      end else if (POWERUP_DONE) begin
         flag_q <= POWERUP_FROM_SUSPEND ? snap_q : RST_FLAG;
      end
   end

   // Rail enable outputs
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         CONVERTER_ENABLES <= 6'h00;
         SWITCH_ENABLES <= 4'h0;
      end else begin
         CONVERTER_ENABLES <= conv_d;
         SWITCH_ENABLES <= sw_d[3:0];
      end
   end

   // Pins 1 and output 2; open drain only ever drives low
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         PIN1_OUT <= 1'b0;
         PIN1_OE <= 1'b0;
         OUT2_OUT <= 1'b0;
         OUT2_OE <= 1'b0;
      end else if (INPUT_SELECT) begin
         PIN1_OUT <= 1'b0;
         PIN1_OE <= 1'b0;
         OUT2_OUT <= 1'b0;
         OUT2_OE <= !PIN1_IN;
      end else begin
         PIN1_OUT <= 1'b0;
         PIN1_OE <= !sw_d[SW_OUT1];
         OUT2_OUT <= 1'b0;
         OUT2_OE <= !sw_d[SW_OUT2];
      end
   end

   // Pin 3, output or low-active warm reset for bucks 1 and 2
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         PIN3_OUT <= 1'b0;
         PIN3_OE <= 1'b0;
         BUCK12_WARM_RESET <= 1'b0;
      end else if (WARM_RESET_PIN_SELECT) begin
         PIN3_OUT <= 1'b0;
         PIN3_OE <= 1'b0;
         BUCK12_WARM_RESET <= !PIN3_IN;
      end else begin
         PIN3_OUT <= 1'b0;
         PIN3_OE <= !sw_d[SW_PIN3];
         BUCK12_WARM_RESET <= 1'b0;
      end
   end

   assign PREADY = pready_q;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;

endmodule

// File: testbench/rlef_assertions.sv
// Concurrent checks on the rail enable register bank ports
`timescale 1ns/1ps
module rlef_checker
   import rlef_pkg::*;
#(
   parameter logic [7:0] KEY = UNLOCK_KEY_DEFAULT
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   // Control and outputs
   input wire logic SEQ_UPDATE,
   input wire logic FRESH_SEAL_STATE,
   input wire logic INPUT_SELECT,
   input wire logic [5:0] CONVERTER_ENABLES,
   input wire logic [3:0] SWITCH_ENABLES,
   input wire logic PIN1_OE,
   input wire logic OUT2_OE
);
   logic wr_done;
   logic armed_q;
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   // Own copy of the one-shot grant; any completed write uses it up
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         armed_q <= 1'h0;
      end else if (wr_done) begin
         armed_q <= (PADDR == ADDR_KEY) && (PWDATA[7:0] == KEY);
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);
   sequence rd_s(logic [7:0] a, logic c);
      PSEL && PENABLE && PREADY && !PWRITE && (PADDR == a) && c;
   endsequence
   key_zero_a: assert property (rd_s(ADDR_KEY, 1'h1) |-> PRDATA == 32'h0)
      else $error("key read not zero");
   conv_read_a: assert property (rd_s(ADDR_CONV, 1'h1) |-> PRDATA == {26'h0, CONVERTER_ENABLES})
      else $error("conv readback wrong");
   sw_read_a: assert property (rd_s(ADDR_SW, 1'h1) |-> !PRDATA[31:7] && PRDATA[3:0] == SWITCH_ENABLES)
      else $error("switch readback wrong");
   seal_six_a: assert property (FRESH_SEAL_STATE |=> !$fell(CONVERTER_ENABLES[5]))
      else $error("backup6 cleared under seal");
   seal_five_a: assert property (FRESH_SEAL_STATE && !SEQ_UPDATE |=> !$fell(CONVERTER_ENABLES[4]))
      else $error("backup5 cleared under seal");
   locked_write_a: assert property (wr_done && PADDR == ADDR_CONV && !armed_q && !SEQ_UPDATE |=>
      $stable(CONVERTER_ENABLES)) else $error("locked write took effect");
   out1_pin_a: assert property (rd_s(ADDR_SW, !INPUT_SELECT && !$past(INPUT_SELECT)) |-> PIN1_OE == !PRDATA[4])
      else $error("pin1 drive wrong");
   out2_pin_a: assert property (rd_s(ADDR_SW, !INPUT_SELECT && !$past(INPUT_SELECT)) |-> OUT2_OE == !PRDATA[5])
      else $error("out2 drive wrong");
endmodule
bind rlef_top rlef_checker #(.KEY(KEY)) u_checker (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .SEQ_UPDATE(SEQ_UPDATE),
   .FRESH_SEAL_STATE(FRESH_SEAL_STATE), .INPUT_SELECT(INPUT_SELECT), .CONVERTER_ENABLES(CONVERTER_ENABLES),
   .SWITCH_ENABLES(SWITCH_ENABLES), .PIN1_OE(PIN1_OE), .OUT2_OE(OUT2_OE));

// File: testbench/rlef_tb.sv
// Self-checking bench for the rail enable register bank
`timescale 1ns/1ps
module testbench
   import rlef_pkg::*;
();
   logic mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, p1_out, p1_oe, o2_out, o2_oe, p3_out, p3_oe, wrst;
   logic sequ = 1'h0, susp = 1'h0, pud = 1'h0, from_susp = 1'h0, seal = 1'h0;
   logic wsel = 1'h0, isel = 1'h0, p1_in = 1'h1, p3_in = 1'h1;
   rlef_seq_t seq_state = 7'h7F;
   logic [5:0] conv_en;
   logic [3:0] sw_en;
   int fail_count = 0, checks = 0;
   always #2 mclk = ~mclk;
   rlef_top #(.KEY(UNLOCK_KEY_DEFAULT)) dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SEQ_UPDATE(sequ), .SEQ_STATE(seq_state), .SUSPEND_ENTRY(susp), .POWERUP_DONE(pud),
      .POWERUP_FROM_SUSPEND(from_susp), .FRESH_SEAL_STATE(seal), .WARM_RESET_PIN_SELECT(wsel),
      .INPUT_SELECT(isel), .CONVERTER_ENABLES(conv_en), .SWITCH_ENABLES(sw_en), .PIN1_IN(p1_in),
      .PIN1_OUT(p1_out), .PIN1_OE(p1_oe), .OUT2_OUT(o2_out), .OUT2_OE(o2_oe), .PIN3_IN(p3_in),
      .PIN3_OUT(p3_out), .PIN3_OE(p3_oe), .BUCK12_WARM_RESET(wrst));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // Ready and read data taken at the rising edge that ends the access, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) begin
         fail_count++;
         summarize();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check(s, rd, e);
   endtask
   task automatic unl();
      apb(1'h1, ADDR_KEY, {24'h0, UNLOCK_KEY_DEFAULT});
   endtask
   task automatic t_reset();
      rdc("flag", ADDR_FLAG, 32'h0);
      rdc("key", ADDR_KEY, 32'h0);
      rdc("conv", ADDR_CONV, 32'h0);
      rdc("sw", ADDR_SW, 32'h0);
      check("oe", {p1_oe, o2_oe, p3_oe}, 32'h7);
      apb(1'h1, 8'hFC, 32'h0);
      check("err", er, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_lock();
      apb(1'h1, ADDR_CONV, 32'h3F);
      rdc("locked", ADDR_CONV, 32'h0);
      unl();
      apb(1'h1, ADDR_CONV, 32'hFF);
      rdc("conv", ADDR_CONV, 32'h3F);
      check("conv pins", conv_en, 32'h3F);
      check("no err", er, 32'h0);
      rdc("key", ADDR_KEY, 32'h0);
      apb(1'h1, ADDR_CONV, 32'h00);
      rdc("one shot", ADDR_CONV, 32'h3F);
      $display("lock test done");
   endtask
   task automatic t_seal();
      seal <= 1'h1;
      unl();
      apb(1'h1, ADDR_CONV, 32'h00);
      rdc("sealed", ADDR_CONV, 32'h30);
      seal <= 1'h0;
      unl();
      apb(1'h1, ADDR_CONV, 32'h00);
      rdc("unsealed", ADDR_CONV, 32'h0);
      $display("seal test done");
   endtask
   task automatic t_sw();
      unl();
      apb(1'h1, ADDR_SW, 32'hA5);
      rdc("sw", ADDR_SW, 32'h25);
      check("sw pins", sw_en, 32'h5);
      check("oe", {p1_oe, o2_oe, p3_oe}, 32'h5);
      unl();
      apb(1'h1, ADDR_SW, 32'h50);
      rdc("sw hiz", ADDR_SW, 32'h50);
      check("sw pins off", sw_en, 32'h0);
      check("oe hiz", {p1_oe, o2_oe, p3_oe}, 32'h2);
      check("low only", {p1_out, o2_out, p3_out}, 32'h0);
      $display("switch test done");
   endtask
   // Sequencer load, suspend snapshot, wake from suspend and from off
   task automatic t_wake();
      sequ <= 1'h1;
      @(posedge mclk);
      sequ <= 1'h0;
      rdc("seq conv", ADDR_CONV, 32'h1F);
      rdc("seq sw", ADDR_SW, 32'h53);
      susp <= 1'h1;
      @(posedge mclk);
      susp <= 1'h0;
      from_susp <= 1'h1;
      pud <= 1'h1;
      @(posedge mclk);
      pud <= 1'h0;
      rdc("wake", ADDR_FLAG, 32'hBF);
      apb(1'h1, ADDR_FLAG, 32'h00);
      rdc("flag ro", ADDR_FLAG, 32'hBF);
      from_susp <= 1'h0;
      pud <= 1'h1;
      @(posedge mclk);
      pud <= 1'h0;
      rdc("cold", ADDR_FLAG, 32'h0);
      $display("wake test done");
   endtask
   task automatic t_modes();
      isel <= 1'h1;
      wsel <= 1'h1;
      // Output bits at 0 would drive low, so the mode override shows
      unl();
      apb(1'h1, ADDR_SW, 32'h00);
      p1_in <= 1'h0;
      p3_in <= 1'h0;
      // Pin outputs are registered; a few edges let them settle
      repeat (4) @(posedge mclk);
      check("in low", {p1_oe, o2_oe, p3_oe, wrst}, 32'h5);
      p1_in <= 1'h1;
      p3_in <= 1'h1;
      repeat (4) @(posedge mclk);
      check("in high", {p1_oe, o2_oe, p3_oe, wrst}, 32'h0);
      $display("mode test done");
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'h1;
      t_reset();
      t_lock();
      t_seal();
      t_sw();
      t_wake();
      t_modes();
      summarize();
   end
endmodule
